/* prom_consts.vh */
// Constants for the registered one-time-programmable word store.
`ifndef PROM_CONSTS_VH
`define PROM_CONSTS_VH
`define PROM_WORDS 1024
`define PROM_ADDR_W 10
`define PROM_DATA_W 8
`define PROM_BLANK_WORD 8'h00
`define PROM_INIT_BLANK 8'h00
`define PROM_SYNC_OFF 1'b1
`endif

/* fuse_word.v */
// One fuse-programmed storage word whose bits can only be set, except that reset clears them all.
`timescale 1ns/10ps
module fuse_word
#(
   parameter WIDTH = 8
)
(
   // Clock and control
   input wire clock_in,
   input wire rst_n_in,
   input wire clk_en_in,
   // Programming
   input wire burn_in,
   input wire [WIDTH-1:0] burn_bits_in,
   // Stored value
   output wire [WIDTH-1:0] word_out
);
   reg [WIDTH-1:0] bits_reg;
   reg [WIDTH-1:0] bits_next;

   // Bits may only go from zero to one.
   always @*
   begin
      bits_next = bits_reg;
      if (burn_in)
      begin
         bits_next = bits_reg | burn_bits_in;
      end
   end

   always @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         bits_reg <= {WIDTH{1'b0}};
      end
      else if (clk_en_in)
      begin
         bits_reg <= bits_next;
      end
   end

   assign word_out = bits_reg;
endmodule

/* registered_prom.v */
// Registered one-time-programmable word store with synchronous and asynchronous enables.
// How it works
// - 1024 words of 8 bits, ten-bit address.
// - Async enable high floats outputs immediately.
// - Sync enable high at a clock-enabled edge floats outputs.
// - Drive only if both enables are low.
// - Sync enable flip-flop starts disabled.
// - Each clock-enabled edge with init high captures addressed word into register.
// - Registered data holds stable until next edge.
// - Init low at edge loads init word.
// - Unprogrammed init word reads all zeros.
// - Bits start zero; programmed ones stay one until a reset clears init word and re-blanks array.
// - Outputs are three-state, driven or released.
`timescale 1ns/10ps
`include "prom_consts.vh"
module registered_prom
#(
   parameter ADDR_W = `PROM_ADDR_W,
   parameter DATA_W = `PROM_DATA_W,
   parameter WORDS = `PROM_WORDS
)
(
   // Clock, reset and clock enable
   input wire clock_in,
   input wire rst_n_in,
   input wire clk_en_in,
   // Read side
   input wire [ADDR_W-1:0] word_address_in,
   input wire sync_chip_enable_n_in,
   input wire async_chip_enable_n_in,
   input wire init_n_in,
   // Programming side
   input wire prog_array_in,
   input wire prog_init_in,
   input wire [ADDR_W-1:0] prog_address_in,
   input wire [DATA_W-1:0] prog_data_in,
   // Data pins
   output wire [DATA_W-1:0] data_out,
   output wire [DATA_W-1:0] data_oe_out
);
   // Blanking sequencer states.
   localparam ST_BLANK = 1'b0;
   localparam ST_READY = 1'b1;
   // Sweep end, address step and the values the flip-flops start from.
   localparam [31:0] LAST_WIDE = WORDS - 1;
   localparam [ADDR_W-1:0] LAST_ADDR = LAST_WIDE[ADDR_W-1:0];
   localparam [ADDR_W-1:0] ADDR_ONE = {{(ADDR_W-1){1'b0}}, 1'b1};
   localparam [DATA_W-1:0] BLANK_WORD = `PROM_BLANK_WORD;
   localparam SYNC_OFF = `PROM_SYNC_OFF;

   reg [DATA_W-1:0] array_mem [0:WORDS-1];
   reg [DATA_W-1:0] out_data_reg;
   reg [DATA_W-1:0] out_data_next;
   reg sync_off_reg;
   reg sync_off_next;
   reg blank_state_reg;
   reg blank_state_next;
   reg [ADDR_W-1:0] clear_addr_reg;
   reg [ADDR_W-1:0] clear_addr_next;
   reg write_en;
   reg [ADDR_W-1:0] write_addr;
   reg [DATA_W-1:0] write_data;
   wire [DATA_W-1:0] init_word;
   wire [DATA_W-1:0] array_word;
   wire [DATA_W-1:0] burn_word;
   wire last_clear;
   wire clear_done;
   wire drive;
   genvar pin;

   // Extra initialize word.
   fuse_word #(.WIDTH(DATA_W)) init_fuse
   (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in),
      .burn_in(prog_init_in),
      .burn_bits_in(prog_data_in),
      .word_out(init_word)
   );

   // Read ports: one for the output register, one for the burn merge.
   assign array_word = array_mem[word_address_in];
   assign burn_word = array_mem[prog_address_in] | prog_data_in;
   assign last_clear = (clear_addr_reg == LAST_ADDR);
   assign clear_done = (blank_state_reg == ST_READY);

   // Select the initialize word or the addressed array word.
   always @*
   begin
      out_data_next = array_word;
      case (init_n_in)
         1'b0:
         begin
            out_data_next = init_word;
         end
         1'b1:
         begin
            out_data_next = array_word;
         end
         default:
         begin
            out_data_next = array_word;
         end
      endcase
   end

   // Single write port: the sweep owns it until done, then programming.
   always @*
   begin
      write_en = 1'b0;
      write_addr = clear_addr_reg;
      write_data = BLANK_WORD;
      if (!clear_done)
      begin
         write_en = 1'b1;
      end
      else if (prog_array_in)
      begin
         write_en = 1'b1;
         write_addr = prog_address_in;
         write_data = burn_word;
      end
   end

   // Array write.
   always @(posedge clock_in)
   begin
      if (clk_en_in && write_en)
      begin
         array_mem[write_addr] <= write_data;
      end
   end

   // Blanking sweep after reset; array programming is refused until it ends.
   always @*
   begin
      blank_state_next = blank_state_reg;
      clear_addr_next = clear_addr_reg;
      case (blank_state_reg)
         ST_BLANK:
         begin
            clear_addr_next = clear_addr_reg + ADDR_ONE;
            if (last_clear)
            begin
               blank_state_next = ST_READY;
            end
         end
         ST_READY:
         begin
            clear_addr_next = clear_addr_reg;
         end
         default:
         begin
            blank_state_next = ST_BLANK;
         end
      endcase
   end

   // Sequencer registers.
   always @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         blank_state_reg <= ST_BLANK;
         clear_addr_reg <= {ADDR_W{1'b0}};
      end
      else if (clk_en_in)
      begin
         blank_state_reg <= blank_state_next;
         clear_addr_reg <= clear_addr_next;
      end
   end

   // Sampled synchronous enable.
   always @*
   begin
      sync_off_next = sync_off_reg;
      if (clk_en_in)
      begin
         sync_off_next = sync_chip_enable_n_in;
      end
   end

   // The sync enable flip-flop powers up floated.
   always @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         sync_off_reg <= SYNC_OFF;
      end
      else
      begin
         sync_off_reg <= sync_off_next;
      end
   end

   // Output register keeps loading while the pins are floated.
   always @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         out_data_reg <= BLANK_WORD;
      end
      else if (clk_en_in)
      begin
         out_data_reg <= out_data_next;
      end
   end

   // Both enables must be low for the pins to drive.
   assign drive = !sync_off_reg && !async_chip_enable_n_in;
   assign data_out = out_data_reg;

   // Each pin carries its own enable, all from the same condition.
   generate
      for (pin = 0; pin < DATA_W; pin = pin + 1)
      begin : g_pin
         assign data_oe_out[pin] = drive;
      end
   endgenerate
endmodule

/* bus_end.sv */
// Far-end bus model that sees the three-state data lines.
`timescale 1ns/10ps
module bus_end(
   input wire logic [7:0] d_in,
   input wire logic [7:0] oe_in,
   output logic [7:0] bus_out
);
   assign bus_out = d_in ^ ~oe_in;
endmodule

/* registered_prom_asserts.sv */
// Assertions for the registered word store.
`timescale 1ns/10ps
module prom_chk(
   input wire logic clock_in, rst_n_in, clk_en_in, init_n_in, prog_init_in, prog_array_in,
   input wire logic sync_chip_enable_n_in, async_chip_enable_n_in,
   input wire logic [9:0] word_address_in, prog_address_in,
   input wire logic [7:0] prog_data_in, data_out, data_oe_out);
   wire s = sync_chip_enable_n_in;
   wire [7:0] p = prog_data_in;
   wire [7:0] e = data_oe_out;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   a_async_off: assert property (async_chip_enable_n_in |-> e == 8'h00)
      else $error("async drive");
   a_sync_off: assert property (clk_en_in && s |=> e == 8'h00)
      else $error("sync drive");
   a_both_on: assert property (clk_en_in && !s ##1 !async_chip_enable_n_in |-> e == 8'hff)
      else $error("no drive");
   a_pins_same: assert property (e == 8'h00 || e == 8'hff)
      else $error("split enable");
   a_data_hold: assert property ($changed(data_out) |-> $past(clk_en_in))
      else $error("data moved");
   a_init_bits: assert property (
      prog_init_in && clk_en_in ##1 !init_n_in && clk_en_in
      |=> (data_out & $past(p, 2)) == $past(p, 2))
      else $error("init bits");
   a_ones_stick: assert property (
      clk_en_in && prog_array_in && prog_address_in == word_address_in
      ##1 clk_en_in && !prog_array_in && init_n_in && $stable(word_address_in)
      |=> (data_out & $past(p, 2)) == $past(p, 2)) else $error("array bits");
   a_init_same: assert property (
      clk_en_in && !init_n_in && !prog_init_in ##1 !init_n_in |=> $stable(data_out))
      else $error("init");
   c_init: cover property (!init_n_in);
   c_prog: cover property (prog_array_in);
   c_float: cover property (s ##1 !s);
   c_freeze: cover property (!clk_en_in ##1 !clk_en_in);
endmodule
bind registered_prom prom_chk u_chk(.*);

/* registered_prom_tb.sv */
// Self-checking testbench for the registered word store.
`timescale 1ns/10ps
module registered_prom_tb;
   logic clock_in = 0, rst_n_in = 0, clk_en_in = 1, init_n_in = 1;
   logic prog_array_in = 0, prog_init_in = 0;
   logic sync_chip_enable_n_in = 1, async_chip_enable_n_in = 1;
   logic [9:0] word_address_in = 0, prog_address_in = 10'h3ff;
   logic [7:0] prog_data_in = 0, data_out, data_oe_out, bus;
   int n_errors = 0, samples_checked = 0;
   registered_prom i_dut(.*);
   bus_end i_bus(.d_in(data_out), .oe_in(data_oe_out), .bus_out(bus));
   initial forever #10 clock_in = ~clock_in;
   task chk(input logic [7:0] g, x);
      samples_checked++;
      if (g !== x)
      begin
         n_errors++;
         $display("mismatch %0t %h %h", $time, g, x);
      end
   endtask
   task tick(input int n);
      repeat (n) @(negedge clock_in);
   endtask
   task close_out;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task power_up;
      tick(20);
      rst_n_in = 1;
      chk(data_oe_out, 8'h00);
      {async_chip_enable_n_in, sync_chip_enable_n_in, init_n_in} = 0;
      tick(1);
      chk(bus, 8'h00);
   endtask
   task burn_init;
      {prog_init_in, prog_data_in} = 9'h15a;
      tick(1);
      prog_init_in = 0;
      tick(2);
      chk(bus, 8'h5a);
   endtask
   task blank_wait;
      init_n_in = 1;
      word_address_in = 10'h3ff;
      tick(1030);
      chk(bus, 8'h00);
   endtask
   task burn_array;
      {prog_array_in, prog_data_in} = 9'h181;
      tick(1);
      prog_data_in = 8'h02;
      tick(1);
      prog_array_in = 0;
      tick(1);
      chk(bus, 8'h83);
   endtask
   task addressing;
      prog_address_in = 10'h155;
      word_address_in = 10'h155;
      prog_data_in = 8'h3c;
      prog_array_in = 1;
      tick(1);
      prog_array_in = 0;
      tick(1);
      chk(bus, 8'h3c);
      word_address_in = 10'h001;
      tick(1);
      chk(bus, 8'h00);
      word_address_in = 10'h3ff;
      tick(1);
      chk(bus, 8'h83);
   endtask
   task async_off;
      async_chip_enable_n_in = 1;
      #1 chk(data_oe_out, 8'h00);
      chk(bus, 8'h7c);
      tick(1);
      async_chip_enable_n_in = 0;
      #1 chk(data_oe_out, 8'hff);
      tick(1);
   endtask
   task sync_off;
      sync_chip_enable_n_in = 1;
      word_address_in = 10'h155;
      chk(data_oe_out, 8'hff);
      tick(1);
      chk(data_oe_out, 8'h00);
      chk(data_out, 8'h3c);
      sync_chip_enable_n_in = 0;
      tick(1);
      chk(bus, 8'h3c);
   endtask
   task freeze;
      clk_en_in = 0;
      word_address_in = 10'h3ff;
      sync_chip_enable_n_in = 1;
      tick(3);
      chk(data_out, 8'h3c);
      chk(data_oe_out, 8'hff);
      clk_en_in = 1;
      sync_chip_enable_n_in = 0;
      tick(1);
      chk(data_out, 8'h83);
   endtask
   task mid_reset;
      rst_n_in = 0;
      init_n_in = 0;
      tick(1);
      chk(data_out, 8'h00);
      chk(data_oe_out, 8'h00);
      rst_n_in = 1;
      tick(1);
      chk(bus, 8'h00);
   endtask
   initial
   begin
      power_up;
      burn_init;
      blank_wait;
      burn_array;
      addressing;
      async_off;
      sync_off;
      freeze;
      mid_reset;
      close_out;
   end
endmodule
